// ==== hdl/abdp_consts.vh ====
// Constants for the analog block digital port: register map, fields, reset values, timing
`ifndef ABDP_CONSTS_VH
`define ABDP_CONSTS_VH

`define ABDP_ADDR_W         8
`define ABDP_DATA_W         32

`define ABDP_OFF_CTRL       8'h00
`define ABDP_OFF_TIMING     8'h04
`define ABDP_OFF_CHAN       8'h08
`define ABDP_OFF_CMD        8'h0C
`define ABDP_OFF_STATUS     8'h10
`define ABDP_OFF_RESULT     8'h14
`define ABDP_OFF_INT_STAT   8'h18
`define ABDP_OFF_INT_MASK   8'h1C
`define ABDP_OFF_QUAD_CM    8'h20
`define ABDP_OFF_QUAD_TM    8'h24
`define ABDP_OFF_QUAD_GD    8'h28

`define ABDP_CTRL_RESET_BIT 0
`define ABDP_CTRL_PD_BIT    1
`define ABDP_CTRL_REF_BIT   2
`define ABDP_CTRL_MODE_LSB  4
`define ABDP_CTRL_MODE_MSB  7
`define ABDP_TIM_DIV_LSB    0
`define ABDP_TIM_DIV_MSB    7
`define ABDP_TIM_STC_LSB    8
`define ABDP_TIM_STC_MSB    15
`define ABDP_CMD_START_BIT  0
`define ABDP_CMD_TEMP_BIT   1

`define ABDP_CTRL_RST_VAL   8'h01
`define ABDP_TIMING_RST_VAL 16'h0000

`define ABDP_EV_DONE        0
`define ABDP_EV_CAL         1
`define ABDP_EV_REFUSED     2
`define ABDP_EV_W           3

`define ABDP_RESULT_BITS    12
`define ABDP_CHAN_W         5
`define ABDP_QUADS          10
`define ABDP_CAL_CYCLES     64
`define ABDP_MEM_DEPTH      256

`endif

// ==== hdl/abdp_cfg_mem.v ====
// Byte-wide configuration memory port, sampled on the system clock, with write and read edges taken from its own clock pin
`timescale 1ns/1ps
`include "abdp_consts.vh"
module abdp_cfg_mem #(
    parameter DEPTH = `ABDP_MEM_DEPTH
) (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       config_mem_clock,
    input  wire       config_mem_reset_n,
    input  wire       config_mem_write_enable,
    input  wire [7:0] config_mem_address,
    input  wire [7:0] config_mem_write_data,
    output reg  [7:0] config_mem_read_data
);
    // Pins come from another clock: two flops each before any use
    reg  [18:0] meta_q;
    reg  [18:0] sync_q;
    reg         clk_prev_q;
    reg  [7:0]  mem [0:DEPTH-1];

    wire        clk_s    = sync_q[0];
    wire        rst_n_s  = sync_q[1];
    wire        wen_s    = sync_q[2];
    wire [7:0]  addr_s   = sync_q[10:3];
    wire [7:0]  wdata_s  = sync_q[18:11];
    // Address and data were synced together with the clock pin, so they are
    // stable here when the synced clock edge is seen
    wire        mem_edge = clk_s & ~clk_prev_q;

    always @(posedge clock)
    begin
        meta_q     <= {config_mem_write_data, config_mem_address,
                       config_mem_write_enable, config_mem_reset_n, config_mem_clock};
        sync_q     <= meta_q;
        clk_prev_q <= clk_s;
    end

    always @(posedge clock)
    begin
        if (mem_edge && rst_n_s && wen_s)
        begin
            mem[addr_s] <= wdata_s;
        end
    end

    always @(posedge clock)
    begin
        if (sys_rst || !rst_n_s)
        begin
            config_mem_read_data <= 8'h00;
        end
        else if (mem_edge)
        begin
            config_mem_read_data <= wen_s ? wdata_s : mem[addr_s];
        end
    end
endmodule // abdp_cfg_mem

// ==== hdl/abdp_top.v ====
// Analog block digital port: converter sequencer, quad controls, registers, config memory
// Functional notes
// - Converter reset bit high holds converter in reset and disables quads.
// - Power-down bit at one powers down the comparator.
// - Busy is high for the whole conversion, low otherwise.
// - Calibration status is high while power-up calibration runs.
// - Result valid rises only when the 12-bit result holds a conversion.
// - Sampling output is high while the input is being acquired.
// - Sampling output is zero whenever nothing is being acquired.
// - Reference select zero drives the internal 2.56 V reference out.
// - Reference select one takes an external reference and ground reference.
// - Config memory reset is active low.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "abdp_consts.vh"
module abdp_top #(
    parameter CAL_CYCLES = `ABDP_CAL_CYCLES,
    parameter QUADS      = `ABDP_QUADS
) (
    input  wire                               clock,
    input  wire                               sys_rst,
    input  wire [`ABDP_ADDR_W-1:0]            bus_addr,
    input  wire [`ABDP_DATA_W-1:0]            bus_wdata,
    input  wire                               bus_wr,
    input  wire                               bus_rd,
    output reg  [`ABDP_DATA_W-1:0]            bus_rdata,
    output reg                                irq,
    input  wire [`ABDP_RESULT_BITS-1:0]       conv_code_in,
    output reg                                busy,
    output reg                                calibrate,
    output reg                                result_valid,
    output reg                                sample,
    output reg  [`ABDP_RESULT_BITS-1:0]       result,
    output reg                                comparator_powerdown,
    output reg                                conv_reset_out,
    output reg                                quad_enable,
    output reg  [3:0]                         conv_mode,
    output reg  [`ABDP_CHAN_W-1:0]            channel_number,
    output reg                                internal_temp_strobe,
    output reg                                reference_pin_oe,
    output reg                                reference_external,
    output reg  [QUADS-1:0]                   current_monitor_strobe,
    output reg  [QUADS-1:0]                   temp_monitor_strobe,
    output reg  [QUADS-1:0]                   gate_drive_on,
    input  wire                               config_mem_clock,
    input  wire                               config_mem_reset_n,
    input  wire                               config_mem_write_enable,
    input  wire [7:0]                         config_mem_address,
    input  wire [7:0]                         config_mem_write_data,
    output wire [7:0]                         config_mem_read_data
);
    localparam [2:0] ST_RESET = 3'd0;
    localparam [2:0] ST_CAL   = 3'd1;
    localparam [2:0] ST_IDLE  = 3'd2;
    localparam [2:0] ST_SAMP  = 3'd3;
    localparam [2:0] ST_CONV  = 3'd4;

    localparam integer CAL_LAST_I  = CAL_CYCLES - 1;
    localparam integer CONV_LAST_I = `ABDP_RESULT_BITS - 1;
    localparam [11:0]  CAL_LAST    = CAL_LAST_I[11:0];
    localparam [11:0]  CONV_LAST   = CONV_LAST_I[11:0];

    function hit;
        input [`ABDP_ADDR_W-1:0] a;
        input [`ABDP_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    reg  [7:0]                    ctrl_q;
    reg  [15:0]                   timing_q;
    reg  [`ABDP_CHAN_W-1:0]       chan_q;
    reg  [QUADS-1:0]              quad_cm_q;
    reg  [QUADS-1:0]              quad_tm_q;
    reg  [QUADS-1:0]              quad_gd_q;
    reg  [`ABDP_EV_W-1:0]         int_stat_q;
    reg  [`ABDP_EV_W-1:0]         int_mask_q;
    reg  [2:0]                    state_q;
    reg  [2:0]                    state_d;
    reg  [11:0]                   cnt_q;
    reg  [11:0]                   cnt_d;
    reg  [7:0]                    pre_q;
    reg  [`ABDP_RESULT_BITS-1:0]  result_q;
    reg                           valid_q;
    reg  [`ABDP_EV_W-1:0]         events;
    reg  [`ABDP_EV_W-1:0]         int_stat_d;
    reg  [`ABDP_DATA_W-1:0]       rdata_d;

    wire       conv_rst    = ctrl_q[`ABDP_CTRL_RESET_BIT];
    wire       pd          = ctrl_q[`ABDP_CTRL_PD_BIT];
    wire [7:0] divide      = timing_q[`ABDP_TIM_DIV_MSB:`ABDP_TIM_DIV_LSB];
    wire [7:0] sample_time = timing_q[`ABDP_TIM_STC_MSB:`ABDP_TIM_STC_LSB];
    wire       wr_cmd      = bus_wr && hit(bus_addr, `ABDP_OFF_CMD);
    wire       start_req   = wr_cmd && bus_wdata[`ABDP_CMD_START_BIT];
    wire       start_ok    = start_req && (state_q == ST_IDLE) && !pd;
    // One tick per (divide + 1) system clocks paces sampling and bit trials
    wire       tick        = (pre_q == divide);

    // Software-written control registers
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            ctrl_q    <= `ABDP_CTRL_RST_VAL;
            timing_q  <= `ABDP_TIMING_RST_VAL;
            chan_q    <= {`ABDP_CHAN_W{1'b0}};
            quad_cm_q <= {QUADS{1'b0}};
            quad_tm_q <= {QUADS{1'b0}};
            quad_gd_q <= {QUADS{1'b0}};
            int_mask_q <= {`ABDP_EV_W{1'b0}};
        end
        else if (bus_wr)
        begin
            if (hit(bus_addr, `ABDP_OFF_CTRL))
                ctrl_q <= bus_wdata[7:0];
            if (hit(bus_addr, `ABDP_OFF_TIMING))
                timing_q <= bus_wdata[15:0];
            if (hit(bus_addr, `ABDP_OFF_CHAN))
                chan_q <= bus_wdata[`ABDP_CHAN_W-1:0];
            if (hit(bus_addr, `ABDP_OFF_QUAD_CM))
                quad_cm_q <= bus_wdata[QUADS-1:0];
            if (hit(bus_addr, `ABDP_OFF_QUAD_TM))
                quad_tm_q <= bus_wdata[QUADS-1:0];
            if (hit(bus_addr, `ABDP_OFF_QUAD_GD))
                quad_gd_q <= bus_wdata[QUADS-1:0];
            if (hit(bus_addr, `ABDP_OFF_INT_MASK))
                int_mask_q <= bus_wdata[`ABDP_EV_W-1:0];
        end
    end

    // Conversion sequencer
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        events  = {`ABDP_EV_W{1'b0}};
        events[`ABDP_EV_REFUSED] = start_req && !start_ok;
        case (state_q)
            ST_RESET:
            begin
                cnt_d = 12'h000;
                if (!conv_rst)
                    state_d = ST_CAL;
            end
            ST_CAL:
            begin
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == CAL_LAST)
                begin
                    state_d = ST_IDLE;
                    cnt_d   = 12'h000;
                    events[`ABDP_EV_CAL] = 1'b1;
                end
            end
            ST_IDLE:
            begin
                cnt_d = 12'h000;
                if (start_ok)
                    state_d = ST_SAMP;
            end
            ST_SAMP:
            begin
                if (pd)
                    state_d = ST_IDLE;
                else if (tick)
                begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == {4'h0, sample_time})
                    begin
                        state_d = ST_CONV;
                        cnt_d   = 12'h000;
                    end
                end
            end
            ST_CONV:
            begin
                if (pd)
                    state_d = ST_IDLE;
                else if (tick)
                begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == CONV_LAST)
                    begin
                        state_d = ST_IDLE;
                        cnt_d   = 12'h000;
                        events[`ABDP_EV_DONE] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = ST_RESET;
                cnt_d   = 12'h000;
            end
        endcase
        // Converter reset overrides everything but the refused event, even a running conversion
        if (conv_rst)
        begin
            state_d = ST_RESET;
            cnt_d   = 12'h000;
            events[`ABDP_EV_DONE] = 1'b0;
            events[`ABDP_EV_CAL]  = 1'b0;
        end
    end

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q  <= ST_RESET;
            cnt_q    <= 12'h000;
            pre_q    <= 8'h00;
            result_q <= {`ABDP_RESULT_BITS{1'b0}};
            valid_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pre_q   <= (start_ok || tick) ? 8'h00 : pre_q + 8'h01;
            if (conv_rst || start_ok)
                valid_q <= 1'b0;
            else if (events[`ABDP_EV_DONE])
            begin
                result_q <= conv_code_in;
                valid_q  <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, write one to clear; a same-cycle event wins
    always @*
    begin
        int_stat_d = int_stat_q;
        if (bus_wr && hit(bus_addr, `ABDP_OFF_INT_STAT))
            int_stat_d = int_stat_d & ~bus_wdata[`ABDP_EV_W-1:0];
        int_stat_d = int_stat_d | events;
    end

    always @*
    begin
        rdata_d = {`ABDP_DATA_W{1'b0}};
        case (bus_addr)
            `ABDP_OFF_CTRL:     rdata_d[7:0] = ctrl_q;
            `ABDP_OFF_TIMING:   rdata_d[15:0] = timing_q;
            `ABDP_OFF_CHAN:     rdata_d[`ABDP_CHAN_W-1:0] = chan_q;
            `ABDP_OFF_STATUS:   rdata_d[3:0] = {sample, result_valid, calibrate, busy};
            `ABDP_OFF_RESULT:   rdata_d[`ABDP_RESULT_BITS-1:0] = result_q;
            `ABDP_OFF_INT_STAT: rdata_d[`ABDP_EV_W-1:0] = int_stat_q;
            `ABDP_OFF_INT_MASK: rdata_d[`ABDP_EV_W-1:0] = int_mask_q;
            `ABDP_OFF_QUAD_CM:  rdata_d[QUADS-1:0] = quad_cm_q;
            `ABDP_OFF_QUAD_TM:  rdata_d[QUADS-1:0] = quad_tm_q;
            `ABDP_OFF_QUAD_GD:  rdata_d[QUADS-1:0] = quad_gd_q;
            default:            rdata_d = {`ABDP_DATA_W{1'b0}};
        endcase
    end

    // Registered outputs; status flags follow the sequencer's next state
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            int_stat_q             <= {`ABDP_EV_W{1'b0}};
            irq                    <= 1'b0;
            bus_rdata              <= {`ABDP_DATA_W{1'b0}};
            busy                   <= 1'b0;
            calibrate              <= 1'b0;
            sample                 <= 1'b0;
            result_valid           <= 1'b0;
            result                 <= {`ABDP_RESULT_BITS{1'b0}};
            comparator_powerdown   <= 1'b0;
            conv_reset_out         <= 1'b1;
            quad_enable            <= 1'b0;
            conv_mode              <= 4'h0;
            channel_number         <= {`ABDP_CHAN_W{1'b0}};
            internal_temp_strobe   <= 1'b0;
            reference_pin_oe       <= 1'b1;
            reference_external     <= 1'b0;
            current_monitor_strobe <= {QUADS{1'b0}};
            temp_monitor_strobe    <= {QUADS{1'b0}};
            gate_drive_on          <= {QUADS{1'b0}};
        end
        else
        begin
            int_stat_q   <= int_stat_d;
            irq          <= |(int_stat_d & int_mask_q);
            bus_rdata    <= bus_rd ? rdata_d : {`ABDP_DATA_W{1'b0}};
            busy         <= (state_d == ST_SAMP) || (state_d == ST_CONV);
            calibrate    <= (state_d == ST_CAL);
            sample       <= (state_d == ST_SAMP);
            result_valid <= !(conv_rst || start_ok) && (valid_q || events[`ABDP_EV_DONE]);
            if (events[`ABDP_EV_DONE])
                result <= conv_code_in;
            comparator_powerdown <= pd;
            conv_reset_out       <= conv_rst;
            quad_enable          <= !conv_rst;
            conv_mode            <= ctrl_q[`ABDP_CTRL_MODE_MSB:`ABDP_CTRL_MODE_LSB];
            channel_number       <= chan_q;
            internal_temp_strobe <= wr_cmd && bus_wdata[`ABDP_CMD_TEMP_BIT];
            // Internal 2.56 V reference is driven only when external is not chosen
            reference_pin_oe     <= !ctrl_q[`ABDP_CTRL_REF_BIT];
            reference_external   <= ctrl_q[`ABDP_CTRL_REF_BIT];
            // Disabled quads see no strobes or gate drive
            current_monitor_strobe <= conv_rst ? {QUADS{1'b0}} : quad_cm_q;
            temp_monitor_strobe    <= conv_rst ? {QUADS{1'b0}} : quad_tm_q;
            gate_drive_on          <= conv_rst ? {QUADS{1'b0}} : quad_gd_q;
        end
    end

    abdp_cfg_mem #(
        .DEPTH (`ABDP_MEM_DEPTH)
    ) u_cfg_mem (
        .clock                   (clock),
        .sys_rst                 (sys_rst),
        .config_mem_clock        (config_mem_clock),
        .config_mem_reset_n      (config_mem_reset_n),
        .config_mem_write_enable (config_mem_write_enable),
        .config_mem_address      (config_mem_address),
        .config_mem_write_data   (config_mem_write_data),
        .config_mem_read_data    (config_mem_read_data)
    );
endmodule // abdp_top

// ==== dv/abdp_analog_model.sv ====
// Analog converter side model: supplies the bit-trial code to the port
`timescale 1ns/1ps
module abdp_analog_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        busy,
    output logic      [11:0] conv_code_in
);
    logic [11:0] code_q;
    logic [11:0] noise_q;
    logic        busy_q;

    // Outside a conversion the code is not held, so it toggles every cycle
    assign conv_code_in = busy ? code_q : noise_q;

    always @(posedge clock)
    begin
        busy_q  <= busy;
        noise_q <= sys_rst ? 12'hA5A : ~noise_q;
        if (sys_rst)
            code_q <= 12'h5A3;
        else if (busy_q && !busy)
            code_q <= code_q + 12'h111;
    end
endmodule // abdp_analog_model

// ==== dv/abdp_top_properties.sv ====
// Port-level assertions for the analog block digital port
`timescale 1ns/1ps
module abdp_top_checker #(
    parameter CAL_CYCLES = 64,
    parameter QUADS      = 10
) (
    input wire logic             clock,
    input wire logic             sys_rst,
    input wire logic [7:0]       bus_addr,
    input wire logic [31:0]      bus_wdata,
    input wire logic             bus_wr,
    input wire logic             busy,
    input wire logic             calibrate,
    input wire logic             result_valid,
    input wire logic             sample,
    input wire logic             comparator_powerdown,
    input wire logic             conv_reset_out,
    input wire logic             quad_enable,
    input wire logic             internal_temp_strobe,
    input wire logic             reference_pin_oe,
    input wire logic             reference_external,
    input wire logic [QUADS-1:0] gate_drive_on,
    input wire logic             config_mem_reset_n,
    input wire logic [7:0]       config_mem_read_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [15:0] cal_cnt_q;
    logic        start_wr;
    assign start_wr = bus_wr && bus_addr == 8'h0C && bus_wdata[0];

    always @(posedge clock)
    begin
        if (sys_rst || !calibrate)
            cal_cnt_q <= 16'h0000;
        else
            cal_cnt_q <= cal_cnt_q + 16'h0001;
    end

    a_reset_quads: assert property (conv_reset_out |-> !quad_enable && gate_drive_on == '0)
        else $error("quads active while converter held in reset");
    a_start_busy: assert property (start_wr && !busy && !calibrate && !conv_reset_out
        && !comparator_powerdown |=> busy && sample && !result_valid)
        else $error("accepted start did not raise busy next cycle");
    a_pd_refuse: assert property (start_wr && comparator_powerdown && !busy |=> (!busy)[*2])
        else $error("conversion started while comparator powered down");
    a_sample_in_busy: assert property (sample |-> busy)
        else $error("sampling outside a conversion");
    a_valid_rise: assert property ($rose(result_valid) |-> $fell(busy))
        else $error("result valid rose without conversion end");
    a_busy_end: assert property ($fell(busy) && !conv_reset_out && !comparator_powerdown
        |-> result_valid && !sample)
        else $error("conversion ended without a valid result");
    a_ref_drive: assert property (reference_pin_oe == !reference_external)
        else $error("reference drive and external select disagree");
    a_cal_length: assert property ($fell(calibrate) && !conv_reset_out
        |-> cal_cnt_q == CAL_CYCLES)
        else $error("calibration length wrong");
    a_temp_pulse: assert property (bus_wr && bus_addr == 8'h0C && bus_wdata[1]
        |=> internal_temp_strobe ##1 !internal_temp_strobe)
        else $error("temperature strobe not a single pulse");
    a_mem_reset: assert property ((!config_mem_reset_n)[*5] |-> config_mem_read_data == 8'h00)
        else $error("config read data not cleared in reset");

    c_conv: cover property ($fell(busy) ##0 result_valid);
    c_cal: cover property ($fell(calibrate));
    c_pd: cover property (start_wr && comparator_powerdown);
endmodule // abdp_top_checker

bind abdp_top abdp_top_checker #(.CAL_CYCLES(CAL_CYCLES), .QUADS(QUADS)) u_chk (
    .clock, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .busy, .calibrate, .result_valid,
    .sample, .comparator_powerdown, .conv_reset_out, .quad_enable, .internal_temp_strobe,
    .reference_pin_oe, .reference_external, .gate_drive_on, .config_mem_reset_n,
    .config_mem_read_data
);

// ==== dv/abdp_top_tb.sv ====
// Self-checking testbench for the analog block digital port
`timescale 1ns/1ps
module abdp_top_tb;
    logic        clock = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic [31:0] bus_rdata;
    logic        irq, busy, calibrate, result_valid, sample, comparator_powerdown;
    logic        conv_reset_out, quad_enable, internal_temp_strobe;
    logic        reference_pin_oe, reference_external;
    logic [3:0]  conv_mode;
    logic [4:0]  channel_number;
    logic [11:0] conv_code_in, result;
    logic [9:0]  cm_strobe, tm_strobe, gd_on;
    logic        mclk = 0, mrst_n = 1, mwe = 0;
    logic [7:0]  maddr = 8'h00, mwdata = 8'h00;
    logic [7:0]  mrdata;
    int          bad_count = 0, n_tests = 0, cnt_b, cnt_s;
    logic [11:0] exp_code = 12'h5A3;

    always #50 clock = ~clock;

    abdp_analog_model u_model (.clock(clock), .sys_rst(sys_rst), .busy(busy),
        .conv_code_in(conv_code_in));

    abdp_top #(.CAL_CYCLES(4)) DUT (
        .clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .conv_code_in(conv_code_in), .busy(busy), .calibrate(calibrate),
        .result_valid(result_valid), .sample(sample), .result(result),
        .comparator_powerdown(comparator_powerdown), .conv_reset_out(conv_reset_out),
        .quad_enable(quad_enable), .conv_mode(conv_mode), .channel_number(channel_number),
        .internal_temp_strobe(internal_temp_strobe), .reference_pin_oe(reference_pin_oe),
        .reference_external(reference_external), .current_monitor_strobe(cm_strobe),
        .temp_monitor_strobe(tm_strobe), .gate_drive_on(gd_on),
        .config_mem_clock(mclk), .config_mem_reset_n(mrst_n),
        .config_mem_write_enable(mwe), .config_mem_address(maddr),
        .config_mem_write_data(mwdata), .config_mem_read_data(mrdata));

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
        @(posedge clock);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 chk(n, bus_rdata, exp);
    endtask

    // Counts cycles of busy and sample from the edge that took the start
    task automatic run_conv(input logic [31:0] tim, input int eb, input int es);
        wr(8'h04, tim);
        wr(8'h0C, 32'h0000_0001);
        #1 cnt_b = 0;
        cnt_s = 0;
        while (busy === 1'b1 && cnt_b < 1000)
        begin
            cnt_b++;
            cnt_s += int'(sample);
            @(posedge clock);
            #1;
        end
        chk("busy_cycles", cnt_b, eb);
        chk("sample_cycles", cnt_s, es);
        chk("result", {result_valid, result}, {1'b1, exp_code});
        exp_code = exp_code + 12'h111;
    endtask

    // Pins held for four system clocks on each side of every config clock edge
    task automatic mem(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        mwe <= we;
        maddr <= a;
        mwdata <= d;
        repeat (4) @(posedge clock);
        mclk <= 1'b1;
        repeat (4) @(posedge clock);
        mclk <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #(60000 * 100);
        bad_count++;
        print_verdict;
    end

    initial
    begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h00, 32'h0000_0001, "ctrl_reset");
        wr(8'h28, 32'h0000_03FF);
        #1 chk("reset_outs", {conv_reset_out, quad_enable, gd_on}, {2'b10, 10'h000});
        chk("ref_internal", {reference_pin_oe, reference_external}, 2'b10);
        rd(8'h3C, 32'h0000_0000, "unmapped");
        $display("reset test done");

        wr(8'h00, 32'h0000_0000);
        // Calibration starts one clock after the reset bit is cleared
        @(posedge clock);
        #1 cnt_b = 0;
        while (calibrate === 1'b1 && cnt_b < 100)
        begin
            cnt_b++;
            @(posedge clock);
            #1;
        end
        chk("cal_cycles", cnt_b, 4);
        chk("gate_drive", gd_on, 10'h3FF);
        wr(8'h20, 32'h0000_0155);
        wr(8'h24, 32'h0000_02AA);
        @(posedge clock);
        #1 chk("quad_strobes", {quad_enable, cm_strobe, tm_strobe}, {1'b1, 20'h556AA});
        rd(8'h18, 32'h0000_0002, "int_cal");
        chk("irq_masked", irq, 1'b0);
        wr(8'h1C, 32'h0000_0002);
        @(posedge clock);
        #1 chk("irq_on", irq, 1'b1);
        wr(8'h18, 32'h0000_0002);
        @(posedge clock);
        #1 chk("irq_off", irq, 1'b0);
        $display("calibration test done");

        wr(8'h08, 32'h0000_0013);
        @(posedge clock);
        #1 chk("channel", channel_number, 5'h13);
        run_conv(32'h0000_0000, 13, 1);
        run_conv(32'h0000_0101, 28, 4);
        rd(8'h10, 32'h0000_0004, "status_valid");
        rd(8'h14, {20'h00000, exp_code - 12'h111}, "result_reg");
        wr(8'h0C, 32'h0000_0001);
        wr(8'h0C, 32'h0000_0001);
        #1 cnt_b = 0;
        while (busy === 1'b1 && cnt_b < 100)
        begin
            cnt_b++;
            @(posedge clock);
            #1;
        end
        // Refused start must not stretch the running conversion
        chk("busy_refused", cnt_b, 26);
        exp_code = exp_code + 12'h111;
        rd(8'h18, 32'h0000_0005, "int_refused");
        wr(8'h18, 32'h0000_0007);
        wr(8'h00, 32'h0000_00A6);
        wr(8'h0C, 32'h0000_0001);
        #1 chk("pd_refused", {comparator_powerdown, busy, conv_mode}, {2'b10, 4'hA});
        chk("ref_external", {reference_pin_oe, reference_external}, 2'b01);
        wr(8'h0C, 32'h0000_0002);
        #1 chk("temp_strobe", internal_temp_strobe, 1'b1);
        @(posedge clock);
        #1 chk("temp_strobe_end", internal_temp_strobe, 1'b0);
        wr(8'h00, 32'h0000_0001);
        @(posedge clock);
        #1 chk("reset_again", {conv_reset_out, gd_on}, {1'b1, 10'h000});
        $display("conversion test done");

        mem(1'b1, 8'h10, 8'hA5);
        mem(1'b0, 8'h10, 8'h99);
        chk("mem_read", mrdata, 8'hA5);
        mrst_n <= 1'b0;
        mem(1'b1, 8'h10, 8'h77);
        chk("mem_reset", mrdata, 8'h00);
        mrst_n <= 1'b1;
        mem(1'b0, 8'h10, 8'h00);
        chk("mem_kept", mrdata, 8'hA5);
        $display("config memory test done");
        print_verdict;
    end
endmodule // abdp_top_tb
